// file: common/gyro_regs_pkg.sv
// register map constants for the banked rate-sensor register file
// assumes a serial front end on the same clock that turns frames into byte accesses
// Function
// - X rate high/low bytes at 0x23/0x24
// - Z rate high/low bytes at 0x25/0x26
// - temperature high/low bytes at 0x29/0x2A
// - write to 0x3F clears parity, reads zero
// - queue samples read repeatedly through 0x3E
// - 0x3C reports available queue samples, resets zero
// - bank 0 holds configuration, bank 1 has no storage and reads zero
// - bank selector at 0x21 maps user bank
// - common bank 0x20-0x3F always reachable
package gyro_regs_pkg;

  // ----------------------------------------
  // common bank offsets
  // ----------------------------------------
  localparam logic [5:0] OFS_COMMON_BASE = 6'h20;
  localparam logic [5:0] OFS_DEVICE_IDENTITY = 6'h20;
  localparam logic [5:0] OFS_BANK_SELECTOR = 6'h21;
  localparam logic [5:0] OFS_SYSTEM_STATE = 6'h22;
  localparam logic [5:0] OFS_RATE_X_HIGH = 6'h23;
  localparam logic [5:0] OFS_RATE_X_LOW = 6'h24;
  localparam logic [5:0] OFS_RATE_Z_HIGH = 6'h25;
  localparam logic [5:0] OFS_RATE_Z_LOW = 6'h26;
  localparam logic [5:0] OFS_THERMAL_HIGH = 6'h29;
  localparam logic [5:0] OFS_THERMAL_LOW = 6'h2A;
  localparam logic [5:0] OFS_HIGHPASS_CLEAR = 6'h3B;
  localparam logic [5:0] OFS_QUEUE_COUNT = 6'h3C;
  localparam logic [5:0] OFS_QUEUE_FLAGS = 6'h3D;
  localparam logic [5:0] OFS_QUEUE_PORT = 6'h3E;
  localparam logic [5:0] OFS_PARITY_CLEAR = 6'h3F;

  // ----------------------------------------
  // user bank 0 configuration slots
  // ----------------------------------------
  localparam int CFG_COUNT = 10;
  localparam int CFG_POWER = 0;
  localparam int CFG_SENSE_LP = 1;
  localparam int CFG_SENSE_RATE = 2;
  localparam int CFG_SENSE_HP = 3;
  localparam int CFG_SAMPLE_READY = 4;
  localparam int CFG_PIN_IO = 5;
  localparam int CFG_TWO_WIRE = 6;
  localparam int CFG_INTERFACE_OTP_SETUP = 7;
  localparam int CFG_QUEUE_TH = 8;
  localparam int CFG_QUEUE_MODE = 9;
  localparam logic [5:0] CFG_OFS [CFG_COUNT] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h13,
                                                6'h14, 6'h15, 6'h16, 6'h17, 6'h18};
  localparam logic [7:0] CFG_RST [CFG_COUNT] = '{8'h07, 8'h28, 8'h23, 8'h00, 8'h01,
                                                8'h00, 8'h04, 8'h00, 8'h00, 8'h00};

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int BANK_SEL_BIT = 0;
  localparam int QUEUE_ENABLE_BIT = 7;
  localparam int SYS_READY_BIT = 0;
  localparam int SYS_PARITY_BIT = 1;
  localparam int QF_EMPTY_BIT = 0;
  localparam int QF_FULL_BIT = 1;
  localparam int QF_THRESH_BIT = 2;
  localparam int QF_OVERRUN_BIT = 3;
  localparam logic [7:0] BANK_SELECTOR_RST = 8'h00;
  localparam logic [7:0] HIGHPASS_CLEAR_RST = 8'h00;
  localparam logic [15:0] SAMPLE_RST = 16'h0000;
  localparam int QUEUE_DEPTH = 16;
  localparam int QUEUE_WIDTH = 16;

  // slot lookup: bit 4 is hit, bits 3:0 the slot index
  function automatic logic [4:0] cfg_lookup(input logic [5:0] addr);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < CFG_COUNT; i++) begin
      if (addr == CFG_OFS[i]) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction : cfg_lookup

endpackage : gyro_regs_pkg

// file: common/sample_stream_if.sv
// word stream between the register map and its sample queue
// assumes both ends run on the same clock
interface sample_stream_if #(parameter int unsigned WIDTH = 16, parameter int unsigned DEPTH = 16);
  logic [WIDTH-1:0] wr_data;
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] rd_data;
  logic rd_valid;
  logic rd_ready;
  logic [$clog2(DEPTH+1)-1:0] count;
  modport producer (output wr_data, wr_valid, rd_ready, input wr_ready, rd_data, rd_valid, count);
  modport store (input wr_data, wr_valid, rd_ready, output wr_ready, rd_data, rd_valid, count);
endinterface : sample_stream_if

// file: core/sample_fifo.sv
// first-word-fall-through sample queue in flip-flops
// assumes an asynchronous active-low reset already released cleanly
module sample_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // stream
  sample_stream_if.store q
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    return (p == PW'(DEPTH-1)) ? '0 : PW'(p + 1'b1);
  endfunction : next_ptr

  // handshakes; full and empty follow the occupancy count
  assign q.wr_ready = (count_q != CW'(DEPTH));
  assign q.rd_valid = (count_q != '0);
  assign q.rd_data = mem_q[rd_ptr_q];
  assign q.count = count_q;
  assign push = q.wr_valid & q.wr_ready;
  assign pop = q.rd_valid & q.rd_ready;

  // storage carries data only, so no reset is spent on it
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= q.wr_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wr_ptr_q <= next_ptr(wr_ptr_q);
      if (pop) rd_ptr_q <= next_ptr(rd_ptr_q);
      if (push && !pop) count_q <= CW'(count_q + 1'b1);
      else if (pop && !push) count_q <= CW'(count_q - 1'b1);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_full_refuses: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (count_q == CW'(DEPTH)) |-> !q.wr_ready) else $error("queue accepts while full");
  a_push_counts: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (push && !pop) |=> (count_q == CW'($past(count_q) + 1'b1))) else $error("push not counted");
  c_queue_full: cover property (@(posedge clk_in) disable iff (!rst_n_in) count_q == CW'(DEPTH));

endmodule : sample_fifo

// file: core/gyro_banked_register_map.sv
// banked register file of the dual-axis rate sensor with its sample queue
// assumes the serial decoder and sensing core run on mclk_in and give one-cycle strobes
module gyro_banked_register_map #(
  parameter int unsigned QUEUE_DEPTH = gyro_regs_pkg::QUEUE_DEPTH,
  parameter logic [7:0] IDENTITY_CODE = 8'h5A // arbitrary value
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // register port from the serial decoder
  input wire logic [5:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // results from the sensing core
  input wire logic [15:0] rate_x_in,
  input wire logic [15:0] rate_z_in,
  input wire logic [15:0] thermal_in,
  input wire logic sample_valid_in,
  input wire logic parity_error_in,
  // configuration toward the core
  output logic [7:0] power_mode_setup_out,
  output logic [7:0] sense_lowpass_ois_setup_out,
  output logic [7:0] sense_output_rate_setup_out,
  output logic [7:0] sense_highpass_setup_out,
  output logic [7:0] sample_ready_setup_out,
  output logic [7:0] pin_io_setup_out,
  output logic [7:0] two_wire_setup_out,
  output logic [7:0] interface_otp_setup_out,
  output logic [7:0] queue_threshold_out,
  output logic [7:0] queue_mode_setup_out,
  output logic highpass_clear_out
);
  localparam int unsigned CW = $clog2(QUEUE_DEPTH+1);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;

  // release is synchronised so no flop leaves reset on a different edge
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] cfg_q [gyro_regs_pkg::CFG_COUNT];
  logic [7:0] bank_q;
  logic [7:0] hp_q;
  logic hp_pulse_q;
  logic [15:0] rate_x_q;
  logic [15:0] rate_z_q;
  logic [15:0] thermal_q;
  logic ready_q;
  logic ready_d;
  logic parity_q;
  logic parity_d;
  logic overrun_q;
  logic overrun_d;
  logic [1:0] pend_q;
  logic [1:0] pend_d;
  logic byte_lo_q;
  logic [7:0] rdata_q;
  logic rvalid_q;

  // queue instance
  sample_stream_if #(.WIDTH(gyro_regs_pkg::QUEUE_WIDTH), .DEPTH(QUEUE_DEPTH)) qbus ();
  sample_fifo #(.WIDTH(gyro_regs_pkg::QUEUE_WIDTH), .DEPTH(QUEUE_DEPTH)) u_queue (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .q(qbus)
  );

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic user_area;
  logic bank1_sel;
  logic [4:0] cfg_look;
  logic cfg_hit;
  logic [3:0] cfg_idx;
  logic cfg_wr;
  logic wr_bank;
  logic wr_hp;
  logic wr_parity;
  logic rd_state;
  logic rd_qflags;
  logic rd_qport;
  logic pop;

  // user area below the common base; bank 1 has no storage here
  assign user_area = (reg_addr_in < gyro_regs_pkg::OFS_COMMON_BASE);
  assign bank1_sel = bank_q[gyro_regs_pkg::BANK_SEL_BIT];
  assign cfg_look = gyro_regs_pkg::cfg_lookup(reg_addr_in);
  assign cfg_hit = cfg_look[4];
  assign cfg_idx = cfg_look[3:0];
  assign cfg_wr = reg_wr_in & user_area & !bank1_sel & cfg_hit;
  assign wr_bank = reg_wr_in & (reg_addr_in == gyro_regs_pkg::OFS_BANK_SELECTOR);
  assign wr_hp = reg_wr_in & (reg_addr_in == gyro_regs_pkg::OFS_HIGHPASS_CLEAR);
  assign wr_parity = reg_wr_in & (reg_addr_in == gyro_regs_pkg::OFS_PARITY_CLEAR);
  assign rd_state = reg_rd_in & (reg_addr_in == gyro_regs_pkg::OFS_SYSTEM_STATE);
  assign rd_qflags = reg_rd_in & (reg_addr_in == gyro_regs_pkg::OFS_QUEUE_FLAGS);
  assign rd_qport = reg_rd_in & (reg_addr_in == gyro_regs_pkg::OFS_QUEUE_PORT);
  // a word leaves the queue only once its low byte has gone out
  assign pop = rd_qport & byte_lo_q & qbus.rd_valid;
  assign qbus.rd_ready = pop;

  // ----------------------------------------
  // queue filling
  // ----------------------------------------
  logic queue_en;
  logic new_set;
  logic lost_set;
  logic push;

  // each sample set becomes an X word then a Z word
  assign queue_en = cfg_q[gyro_regs_pkg::CFG_QUEUE_MODE][gyro_regs_pkg::QUEUE_ENABLE_BIT];
  assign new_set = sample_valid_in & queue_en;
  // a full queue stalls the sequencer; a set arriving while stalled is dropped
  assign lost_set = new_set & (|pend_q);
  assign qbus.wr_valid = |pend_q;
  assign qbus.wr_data = pend_q[0] ? rate_x_q : rate_z_q;
  assign push = qbus.wr_valid & qbus.wr_ready;
  assign pend_d = (new_set && pend_q == 2'h0) ? 2'h3 :
                  !push ? pend_q :
                  pend_q[0] ? {pend_q[1], 1'b0} : 2'h0;

  // sticky flags: the hardware set beats a clear in the same cycle
  assign ready_d = sample_valid_in | (ready_q & !rd_state);
  assign parity_d = parity_error_in | (parity_q & !wr_parity);
  assign overrun_d = lost_set | (overrun_q & !rd_qflags);

  // ----------------------------------------
  // read selection
  // ----------------------------------------
  logic [7:0] x_hi_w;
  logic [7:0] x_lo_w;
  logic [7:0] z_hi_w;
  logic [7:0] z_lo_w;
  logic [7:0] t_hi_w;
  logic [7:0] t_lo_w;
  logic [7:0] count_w;
  logic thresh_hit;
  logic [7:0] sys_w;
  logic [7:0] qflags_w;
  logic [7:0] qport_w;
  logic [7:0] user_rd;
  logic [7:0] common_rd;
  logic [7:0] rd_sel;

  // result bytes
  assign x_hi_w = rate_x_q[15:8];
  assign x_lo_w = rate_x_q[7:0];
  assign z_hi_w = rate_z_q[15:8];
  assign z_lo_w = rate_z_q[7:0];
  assign t_hi_w = thermal_q[15:8];
  assign t_lo_w = thermal_q[7:0];
  assign count_w = 8'(qbus.count);

  // status words
  assign thresh_hit = (cfg_q[gyro_regs_pkg::CFG_QUEUE_TH] != 8'h00) &&
                      (count_w >= cfg_q[gyro_regs_pkg::CFG_QUEUE_TH]);
  assign sys_w = ({7'h00, ready_q} << gyro_regs_pkg::SYS_READY_BIT) |
                 ({7'h00, parity_q} << gyro_regs_pkg::SYS_PARITY_BIT);
  assign qflags_w = ({7'h00, !qbus.rd_valid} << gyro_regs_pkg::QF_EMPTY_BIT) |
                    ({7'h00, !qbus.wr_ready} << gyro_regs_pkg::QF_FULL_BIT) |
                    ({7'h00, thresh_hit} << gyro_regs_pkg::QF_THRESH_BIT) |
                    ({7'h00, overrun_q} << gyro_regs_pkg::QF_OVERRUN_BIT);
  // empty queue reads as zero; high byte first, then low byte
  assign qport_w = !qbus.rd_valid ? 8'h00 : byte_lo_q ? qbus.rd_data[7:0] : qbus.rd_data[15:8];

  // user bank view: bank 1 and unlisted slots read zero
  assign user_rd = (bank1_sel || !cfg_hit) ? 8'h00 : cfg_q[cfg_idx];
  // common bank view; parity clear and gaps fall through to zero
  assign common_rd =
    (reg_addr_in == gyro_regs_pkg::OFS_DEVICE_IDENTITY) ? IDENTITY_CODE :
    (reg_addr_in == gyro_regs_pkg::OFS_BANK_SELECTOR) ? bank_q :
    (reg_addr_in == gyro_regs_pkg::OFS_SYSTEM_STATE) ? sys_w :
    (reg_addr_in == gyro_regs_pkg::OFS_RATE_X_HIGH) ? x_hi_w :
    (reg_addr_in == gyro_regs_pkg::OFS_RATE_X_LOW) ? x_lo_w :
    (reg_addr_in == gyro_regs_pkg::OFS_RATE_Z_HIGH) ? z_hi_w :
    (reg_addr_in == gyro_regs_pkg::OFS_RATE_Z_LOW) ? z_lo_w :
    (reg_addr_in == gyro_regs_pkg::OFS_THERMAL_HIGH) ? t_hi_w :
    (reg_addr_in == gyro_regs_pkg::OFS_THERMAL_LOW) ? t_lo_w :
    (reg_addr_in == gyro_regs_pkg::OFS_HIGHPASS_CLEAR) ? hp_q :
    (reg_addr_in == gyro_regs_pkg::OFS_QUEUE_COUNT) ? count_w :
    (reg_addr_in == gyro_regs_pkg::OFS_QUEUE_FLAGS) ? qflags_w :
    (reg_addr_in == gyro_regs_pkg::OFS_QUEUE_PORT) ? qport_w :
    8'h00;
  assign rd_sel = user_area ? user_rd : common_rd;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // bank 0 configuration; writes elsewhere in the user area are dropped
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < gyro_regs_pkg::CFG_COUNT; i++) cfg_q[i] <= gyro_regs_pkg::CFG_RST[i];
    end else if (cfg_wr) begin
      cfg_q[cfg_idx] <= reg_wdata_in;
    end
  end

  // common bank writable locations
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      bank_q <= gyro_regs_pkg::BANK_SELECTOR_RST;
      hp_q <= gyro_regs_pkg::HIGHPASS_CLEAR_RST;
      hp_pulse_q <= 1'b0;
    end else begin
      if (wr_bank) bank_q <= reg_wdata_in;
      if (wr_hp) hp_q <= reg_wdata_in;
      hp_pulse_q <= wr_hp;
    end
  end

  // result capture; all three results are replaced together on each sample_valid_in, with no hold between high and low byte reads
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rate_x_q <= gyro_regs_pkg::SAMPLE_RST;
      rate_z_q <= gyro_regs_pkg::SAMPLE_RST;
      thermal_q <= gyro_regs_pkg::SAMPLE_RST;
    end else if (sample_valid_in) begin
      rate_x_q <= rate_x_in;
      rate_z_q <= rate_z_in;
      thermal_q <= thermal_in;
    end
  end

  // flags, sequencer and burst byte phase
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
      parity_q <= 1'b0;
      overrun_q <= 1'b0;
      pend_q <= 2'h0;
      byte_lo_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
      parity_q <= parity_d;
      overrun_q <= overrun_d;
      pend_q <= pend_d;
      if (rd_qport && qbus.rd_valid) byte_lo_q <= !byte_lo_q;
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_in;
      if (reg_rd_in) rdata_q <= rd_sel;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;
  assign highpass_clear_out = hp_pulse_q;
  assign power_mode_setup_out = cfg_q[gyro_regs_pkg::CFG_POWER];
  assign sense_lowpass_ois_setup_out = cfg_q[gyro_regs_pkg::CFG_SENSE_LP];
  assign sense_output_rate_setup_out = cfg_q[gyro_regs_pkg::CFG_SENSE_RATE];
  assign sense_highpass_setup_out = cfg_q[gyro_regs_pkg::CFG_SENSE_HP];
  assign sample_ready_setup_out = cfg_q[gyro_regs_pkg::CFG_SAMPLE_READY];
  assign pin_io_setup_out = cfg_q[gyro_regs_pkg::CFG_PIN_IO];
  assign two_wire_setup_out = cfg_q[gyro_regs_pkg::CFG_TWO_WIRE];
  assign interface_otp_setup_out = cfg_q[gyro_regs_pkg::CFG_INTERFACE_OTP_SETUP];
  assign queue_threshold_out = cfg_q[gyro_regs_pkg::CFG_QUEUE_TH];
  assign queue_mode_setup_out = cfg_q[gyro_regs_pkg::CFG_QUEUE_MODE];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  a_x_high_byte: assert property ((reg_rd_in && reg_addr_in == gyro_regs_pkg::OFS_RATE_X_HIGH)
    |=> reg_rvalid_out && reg_rdata_out == $past(x_hi_w)) else $error("x high byte wrong");
  a_x_low_byte: assert property ((reg_rd_in && reg_addr_in == gyro_regs_pkg::OFS_RATE_X_LOW)
    |=> reg_rdata_out == $past(x_lo_w)) else $error("x low byte wrong");
  a_z_low_byte: assert property ((reg_rd_in && reg_addr_in == gyro_regs_pkg::OFS_RATE_Z_LOW)
    |=> reg_rdata_out == $past(z_lo_w)) else $error("z low byte wrong");
  a_thermal_high: assert property ((reg_rd_in && reg_addr_in == gyro_regs_pkg::OFS_THERMAL_HIGH)
    |=> reg_rdata_out == $past(t_hi_w)) else $error("thermal high byte wrong");
  a_parity_clear_write: assert property ((wr_parity && !parity_error_in)
    |=> !parity_q) else $error("parity flag survived clear");
  a_parity_reads_zero: assert property ((reg_rd_in && reg_addr_in == gyro_regs_pkg::OFS_PARITY_CLEAR)
    |=> reg_rdata_out == 8'h00) else $error("parity clear read nonzero");
  a_burst_pop: assert property ((rd_qport && byte_lo_q && qbus.rd_valid && !push)
    |=> qbus.count == CW'($past(qbus.count) - 1'b1) && !byte_lo_q) else $error("burst word not popped");
  a_count_report: assert property ((reg_rd_in && reg_addr_in == gyro_regs_pkg::OFS_QUEUE_COUNT)
    |=> reg_rdata_out == $past(count_w)) else $error("count read wrong");
  a_bank0_write: assert property ((reg_wr_in && !bank1_sel && reg_addr_in == 6'h00)
    |=> power_mode_setup_out == $past(reg_wdata_in)) else $error("bank 0 write lost");
  a_bank1_hidden: assert property ((reg_rd_in && user_area && bank1_sel)
    |=> reg_rdata_out == 8'h00) else $error("bank 1 read nonzero");
  a_selector_common: assert property ((reg_rd_in && reg_addr_in == gyro_regs_pkg::OFS_BANK_SELECTOR)
    |=> reg_rdata_out == $past(bank_q)) else $error("selector read wrong");
  a_reserved_zero: assert property ((reg_rd_in && reg_addr_in == 6'h27) ##1 1'b1
    |-> reg_rdata_out == 8'h00) else $error("reserved read nonzero");

  c_burst_word: cover property (rd_qport && !byte_lo_q && qbus.rd_valid ##1 rd_qport && byte_lo_q);
  c_bank_switch: cover property (wr_bank ##[1:4] (reg_rd_in && user_area && bank1_sel));
  c_set_lost: cover property (lost_set);

endmodule : gyro_banked_register_map

// file: testbench/host_port_model.sv
// host-side model: turns byte reads and writes into register-port strobes
// assumes the design samples on the rising edge; this model moves only on falling edges
module host_port_model (
  // clock
  input wire logic clk_in,
  // register port toward the design
  output logic [5:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle lines carry the inverse of the last value, so stale data never looks valid
  initial begin
    addr_out = 6'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // one write strobe, held through the taking edge; also programs the bank selector
  task automatic write_byte(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask : write_byte

  // one read strobe; the answer is taken one cycle later, repeated calls form a burst
  task automatic read_byte(input logic [5:0] a, output logic [7:0] d, output logic v);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    v = rvalid_in;
    d = rdata_in;
    rd_out = 1'b0;
    addr_out = ~a;
  endtask : read_byte
endmodule : host_port_model

// file: testbench/test_gyro_banked_register_map.sv
// self-checking bench for the banked register map with its sample queue
// assumes the design answers reads one cycle after the strobe and queues X then Z words
module test_gyro_banked_register_map;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam logic [7:0] ID_CODE = 8'h3C; // arbitrary value
  typedef struct {logic [5:0] a; logic [7:0] rst; logic [7:0] wd; logic [7:0] aft;} row_s;
  logic mclk, rst_n, wr, rd, rvalid, sval, perr, hp_clr;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, pwr, qmode;
  logic [15:0] rx, rz, th;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  row_s rows [19] = '{'{6'h00, 8'h07, 8'h5A, 8'h5A}, '{6'h01, 8'h28, 8'h11, 8'h11}, '{6'h02, 8'h23, 8'h22, 8'h22},
    '{6'h03, 8'h00, 8'h33, 8'h33}, '{6'h13, 8'h01, 8'h44, 8'h44}, '{6'h14, 8'h00, 8'h55, 8'h55},
    '{6'h15, 8'h04, 8'h66, 8'h66}, '{6'h16, 8'h00, 8'h77, 8'h77}, '{6'h17, 8'h00, 8'h04, 8'h04},
    '{6'h18, 8'h00, 8'h80, 8'h80}, '{6'h1A, 8'h00, 8'hFF, 8'h00}, '{6'h1B, 8'h00, 8'hFF, 8'h00},
    '{6'h04, 8'h00, 8'hFF, 8'h00}, '{6'h19, 8'h00, 8'hFF, 8'h00}, '{6'h20, ID_CODE, 8'hFF, ID_CODE},
    '{6'h27, 8'h00, 8'hFF, 8'h00}, '{6'h2B, 8'h00, 8'hFF, 8'h00}, '{6'h3C, 8'h00, 8'hFF, 8'h00},
    '{6'h3F, 8'h00, 8'hFF, 8'h00}};

  gyro_banked_register_map #(.QUEUE_DEPTH(gyro_regs_pkg::QUEUE_DEPTH), .IDENTITY_CODE(ID_CODE)) DUT (
    .mclk_in(mclk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .rate_x_in(rx), .rate_z_in(rz),
    .thermal_in(th), .sample_valid_in(sval), .parity_error_in(perr), .power_mode_setup_out(pwr),
    .sense_lowpass_ois_setup_out(), .sense_output_rate_setup_out(), .sense_highpass_setup_out(),
    .sample_ready_setup_out(), .pin_io_setup_out(), .two_wire_setup_out(), .interface_otp_setup_out(),
    .queue_threshold_out(), .queue_mode_setup_out(qmode), .highpass_clear_out(hp_clr));

  host_port_model u_host (.clk_in(mclk), .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata),
    .rdata_in(rdata), .rvalid_in(rvalid));

  // ----------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // a few thousand cycles cover every scenario with wide margin
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // read one byte and compare both the data and its valid pulse
  task automatic rc(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    u_host.read_byte(a, d, v);
    check($sformatf("valid at %h", a), 8'h01, {7'h00, v});
    check($sformatf("data at %h", a), exp, d);
  endtask : rc

  // one sample set from the sensing core, held until the next set
  task automatic push(input logic [15:0] x, input logic [15:0] z, input logic [15:0] t);
    @(negedge mclk);
    rx = x;
    rz = z;
    th = t;
    sval = 1'b1;
    @(negedge mclk);
    sval = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : push

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
  endtask : do_reset

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {sval, perr, rx, rz, th} = '0;
    do_reset();
    // reset value, write, read back for each row
    foreach (rows[i]) begin
      rc(rows[i].a, rows[i].rst);
      u_host.write_byte(rows[i].a, rows[i].wd);
      rc(rows[i].a, rows[i].aft);
    end
    check("power out", 8'h5A, pwr);
    check("queue mode out", 8'h80, qmode);
    $display("done: register table");
    // bank 1 hides bank 0, common bank stays reachable
    u_host.write_byte(6'h21, 8'h01);
    rc(6'h00, 8'h00);
    u_host.write_byte(6'h00, 8'h99);
    rc(6'h21, 8'h01);
    rc(6'h20, ID_CODE);
    u_host.write_byte(6'h21, 8'h00);
    rc(6'h00, 8'h5A);
    $display("done: bank select");
    // result bytes and status flags
    push(16'h1234, 16'hABCD, 16'h5678);
    rc(6'h23, 8'h12);
    rc(6'h24, 8'h34);
    rc(6'h25, 8'hAB);
    rc(6'h26, 8'hCD);
    rc(6'h29, 8'h56);
    rc(6'h2A, 8'h78);
    @(negedge mclk);
    perr = 1'b1;
    @(negedge mclk);
    perr = 1'b0;
    rc(6'h22, 8'h03);
    rc(6'h22, 8'h02);
    u_host.write_byte(6'h3F, 8'h5A);
    rc(6'h22, 8'h00);
    u_host.write_byte(6'h3B, 8'h01);
    check("highpass pulse", 8'h01, {7'h00, hp_clr});
    $display("done: results and clears");
    // the set captured above is still queued: drain it first, high byte then low byte
    rc(6'h3E, 8'h12);
    rc(6'h3E, 8'h34);
    rc(6'h3E, 8'hAB);
    rc(6'h3E, 8'hCD);
    // eight sets fill the queue, the ninth waits stalled, the tenth is dropped
    for (int k = 0; k < 10; k++) begin
      push(16'(16'h0101 * k), ~16'(16'h0101 * k), 16'h0000);
    end
    rc(6'h3C, 8'h10);
    rc(6'h3D, 8'h0E);
    rc(6'h3D, 8'h06);
    // the stalled set is pushed from the newest capture, so it carries the tenth values
    for (int k = 0; k < 9; k++) begin
      rc(6'h3E, 8'(k + k / 8));
      rc(6'h3E, 8'(k + k / 8));
      rc(6'h3E, ~8'(k + k / 8));
      rc(6'h3E, ~8'(k + k / 8));
    end
    rc(6'h3C, 8'h00);
    rc(6'h3E, 8'h00);
    $display("done: queue fill and drain");
    // second reset in mid-run brings the defaults back
    do_reset();
    rc(6'h00, 8'h07);
    rc(6'h21, 8'h00);
    $display("done: second reset");
    complete_run();
  end
endmodule : test_gyro_banked_register_map
